// [icp_pkg.sv]
`default_nettype none
package icp_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int ICP_NSRC  = 16;
  localparam int ICP_NPRIO = 5;
  localparam int ICP_NEV   = 17;
  localparam int ICP_ERR   = 16;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ICP_OFS_EN    = 8'h00;
  localparam logic [7:0] ICP_OFS_PRIO0 = 8'h04;
  localparam logic [7:0] ICP_OFS_STEP  = 8'h04;
  localparam logic [7:0] ICP_OFS_FLAG  = 8'h18;
  localparam logic [7:0] ICP_OFS_STAT  = 8'h1c;
  localparam logic [7:0] ICP_OFS_MASK  = 8'h20;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int          ICP_ERR_EN_BIT = 1;
  localparam logic [15:0] ICP_EN_MASK    = 16'h0002;
  localparam logic [15:0] ICP_EN_RST     = 16'h0000;
  localparam logic [2:0]  ICP_PRIO_OFF   = 3'h0;
  localparam logic [15:0] ICP_PRIO_MASK [ICP_NPRIO] =
    '{16'h7777, 16'h7770, 16'h7777, 16'h0077, 16'h7077};
  localparam logic [15:0] ICP_PRIO_RST [ICP_NPRIO] =
    '{16'h4444, 16'h4440, 16'h4444, 16'h0044, 16'h4044};
  localparam logic [16:0] ICP_EV_RST = 17'h00000;

  // source order: ext_pin_zero, capture_one, compare_one, timer_one,
  // capture_two, compare_two, timer_two, timer_three, spi_error,
  // spi_event, serial_receive, serial_transmit, converter_done,
  // twowire_slave, twowire_master, change_notify
  localparam int ICP_SRC_REG [ICP_NSRC] =
    '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4};
  localparam int ICP_SRC_LSB [ICP_NSRC] =
    '{0, 4, 8, 12, 4, 8, 12, 0, 4, 8, 12, 0, 4, 0, 4, 12};

  // ------------------------------------------------------------
  // bus answers and carriers
  // ------------------------------------------------------------
  localparam logic [1:0] ICP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ICP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [2:0] level;
  } icp_req_t;
endpackage
`default_nettype wire

// [icp_regs.sv]
// Behaviour
// - priority field value is the level directly
// - priority zero never presents a request
// - enable bit 1 gates serial error source
// - unimplemented bits read zero, ignore writes
// - priority fields reset to level four
// - serial error enable resets to zero
// - first priority register field layout
// - second priority register field layout
// - third priority register field layout
// - fourth priority register field layout
// - fifth priority register field layout
// - flag reads one once request occurred; here FLAG reads the live i_src_flag and STAT holds each new request
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`default_nettype none
module icp_regs (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [7:0]            i_s_axi_awaddr,
  input  wire logic                  i_s_axi_awvalid,
  output logic                       o_s_axi_awready,
  input  wire logic [31:0]           i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  input  wire logic                  i_s_axi_wvalid,
  output logic                       o_s_axi_wready,
  output logic [1:0]                 o_s_axi_bresp,
  output logic                       o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  input  wire logic [7:0]            i_s_axi_araddr,
  input  wire logic                  i_s_axi_arvalid,
  output logic                       o_s_axi_arready,
  output logic [31:0]                o_s_axi_rdata,
  output logic [1:0]                 o_s_axi_rresp,
  output logic                       o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready,
  input  wire logic [16:0]           i_src_flag,
  input  wire logic [15:0]           i_src_enable,
  input  wire logic [2:0]            i_serial_error_priority,
  output icp_pkg::icp_req_t [16:0]   o_req,
  output logic                       o_irq
);
  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        wr_fire;
  logic        wr_hit;
  logic [15:0] wr_bytes;

  assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_bytes = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_comb begin
    wr_hit = (aw_addr_q == icp_pkg::ICP_OFS_EN) || (aw_addr_q == icp_pkg::ICP_OFS_FLAG) ||
             (aw_addr_q == icp_pkg::ICP_OFS_STAT) || (aw_addr_q == icp_pkg::ICP_OFS_MASK);
    for (int k = 0; k < icp_pkg::ICP_NPRIO; k++) begin
      if (aw_addr_q == icp_pkg::ICP_OFS_PRIO0 + 8'(k * 4)) begin
        wr_hit = 1'b1;
      end
    end
  end

  // address and data are taken in either order; the answer waits for both
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= icp_pkg::ICP_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && awready_q) begin
        aw_addr_q <= i_s_axi_awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (i_s_axi_wvalid && wready_q) begin
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? icp_pkg::ICP_RESP_OKAY : icp_pkg::ICP_RESP_SLVERR;
      end
      if (bvalid_q && i_s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready  = wready_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [15:0] en_q;
  logic [15:0] prio_q [icp_pkg::ICP_NPRIO];
  logic [16:0] mask_q;
  logic [15:0] en_bits;

  assign en_bits = wr_bytes & icp_pkg::ICP_EN_MASK;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      en_q <= icp_pkg::ICP_EN_RST;
    end else if (wr_fire && aw_addr_q == icp_pkg::ICP_OFS_EN) begin
      en_q <= (en_q & ~en_bits) | (w_data_q[15:0] & en_bits);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    for (int k = 0; k < icp_pkg::ICP_NPRIO; k++) begin
      if (i_sys_rst) begin
        prio_q[k] <= icp_pkg::ICP_PRIO_RST[k];
      end else if (wr_fire && aw_addr_q == icp_pkg::ICP_OFS_PRIO0 + 8'(k * 4)) begin
        // unimplemented positions keep their zero
        prio_q[k] <= (prio_q[k] & ~(wr_bytes & icp_pkg::ICP_PRIO_MASK[k])) |
                     (w_data_q[15:0] & wr_bytes & icp_pkg::ICP_PRIO_MASK[k]);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mask_q <= icp_pkg::ICP_EV_RST;
    end else if (wr_fire && aw_addr_q == icp_pkg::ICP_OFS_MASK) begin
      mask_q <= (mask_q & ~{w_strb_q[2], {8{w_strb_q[1]}}, {8{w_strb_q[0]}}}) |
                (w_data_q[16:0] & {w_strb_q[2], {8{w_strb_q[1]}}, {8{w_strb_q[0]}}});
    end
  end

  // ------------------------------------------------------------
  // request forwarding
  // ------------------------------------------------------------
  logic [2:0]  src_level [icp_pkg::ICP_NEV];
  logic [16:0] src_enable;
  logic [16:0] req_d;
  icp_pkg::icp_req_t [16:0] req_q;

  assign src_enable = {en_q[icp_pkg::ICP_ERR_EN_BIT], i_src_enable};
  assign src_level[icp_pkg::ICP_ERR] = i_serial_error_priority;

  for (genvar i = 0; i < icp_pkg::ICP_NSRC; i++) begin : g_lvl
    // field value is the level as is
    assign src_level[i] = prio_q[icp_pkg::ICP_SRC_REG[i]][icp_pkg::ICP_SRC_LSB[i] +: 3];
  end

  for (genvar i = 0; i < icp_pkg::ICP_NEV; i++) begin : g_req
    // a zero level blocks the source whatever its flag and enable
    assign req_d[i] = i_src_flag[i] && src_enable[i] && (src_level[i] != icp_pkg::ICP_PRIO_OFF);

    chk_req_zero_level: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (src_level[i] == icp_pkg::ICP_PRIO_OFF) |=> !req_q[i].valid)
      else $error("request with zero priority");
    chk_req_level_tag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_src_flag[i] && src_enable[i] && src_level[i] != 3'h0) |=>
      (req_q[i].valid && req_q[i].level == $past(src_level[i])))
      else $error("request level differs from field");
    chk_req_flag_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !(i_src_flag[i] && src_enable[i]) |=> !req_q[i].valid)
      else $error("request without flag and enable");
    chk_req_idle_level: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !req_q[i].valid |-> (req_q[i].level == icp_pkg::ICP_PRIO_OFF))
      else $error("idle request carries a level");
  end

  always_ff @(posedge i_ref_clk) begin
    for (int k = 0; k < icp_pkg::ICP_NEV; k++) begin
      if (i_sys_rst) begin
        req_q[k] <= '0;
      end else begin
        req_q[k].valid <= req_d[k];
        req_q[k].level <= req_d[k] ? src_level[k] : icp_pkg::ICP_PRIO_OFF;
      end
    end
  end

  assign o_req = req_q;

  // ------------------------------------------------------------
  // sticky event status and interrupt
  // ------------------------------------------------------------
  logic [16:0] stat_q;
  logic [16:0] stat_set;
  logic [16:0] stat_clr;
  logic [16:0] stat_d;
  logic [16:0] req_prev;
  logic        irq_q;

  for (genvar i = 0; i < icp_pkg::ICP_NEV; i++) begin : g_prev
    assign req_prev[i] = req_q[i].valid;
  end

  // an event is a newly forwarded request
  assign stat_set = req_d & ~req_prev;
  assign stat_clr = (wr_fire && aw_addr_q == icp_pkg::ICP_OFS_STAT) ?
                    (w_data_q[16:0] & {w_strb_q[2], {8{w_strb_q[1]}}, {8{w_strb_q[0]}}}) : 17'h00000;
  // set wins over a clear in the same cycle
  assign stat_d = (stat_q & ~stat_clr) | stat_set;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      stat_q <= icp_pkg::ICP_EV_RST;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |(stat_d & mask_q);
    end
  end

  assign o_irq = irq_q;

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_data;
  logic        rd_hit;

  always_comb begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    unique case (i_s_axi_araddr)
      icp_pkg::ICP_OFS_EN:   rd_data = {16'h0000, en_q};
      icp_pkg::ICP_OFS_FLAG: rd_data = {15'h0000, i_src_flag};
      icp_pkg::ICP_OFS_STAT: rd_data = {15'h0000, stat_q};
      icp_pkg::ICP_OFS_MASK: rd_data = {15'h0000, mask_q};
      default:               rd_hit  = 1'b0;
    endcase
    for (int k = 0; k < icp_pkg::ICP_NPRIO; k++) begin
      if (i_s_axi_araddr == icp_pkg::ICP_OFS_PRIO0 + 8'(k * 4)) begin
        rd_data = {16'h0000, prio_q[k]};
        rd_hit  = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= icp_pkg::ICP_RESP_OKAY;
    end else if (i_s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_hit ? icp_pkg::ICP_RESP_OKAY : icp_pkg::ICP_RESP_SLVERR;
    end else if (rvalid_q && i_s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_rst_release;
    $past(i_sys_rst) && !i_sys_rst;
  endsequence

  sequence s_wr_both;
    aw_have_q && w_have_q && !bvalid_q;
  endsequence

  sequence s_rd_take;
    i_s_axi_arvalid && arready_q;
  endsequence

  chk_prio_reset_val: assert property (@(posedge i_ref_clk)
    s_rst_release |-> (prio_q[0] == 16'h4444 && prio_q[1] == 16'h4440 && prio_q[2] == 16'h4444 &&
                       prio_q[3] == 16'h0044 && prio_q[4] == 16'h4044))
    else $error("priority reset value wrong");
  chk_en_reset_zero: assert property (@(posedge i_ref_clk)
    s_rst_release |-> !en_q[1] ##1 !req_q[16].valid)
    else $error("serial error enable not cleared");
  chk_unimpl_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ((prio_q[1] & 16'h800f) == 16'h0000) && ((prio_q[3] & 16'hff88) == 16'h0000) && ((en_q & 16'hfffd) == 16'h0))
    else $error("unimplemented bit set");
  chk_err_en_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !en_q[1] |=> !req_q[16].valid)
    else $error("serial error request while disabled");
  chk_write_answer: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_wr_both |=> bvalid_q && !aw_have_q)
    else $error("write answer missing");
  chk_flag_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_s_axi_arvalid && arready_q && i_s_axi_araddr == 8'h18) |=> rdata_q[16:0] == $past(i_src_flag))
    else $error("flag readback wrong");
  chk_prio_holes: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ((prio_q[0] & 16'h8888) == 16'h0000) && ((prio_q[2] & 16'h8888) == 16'h0000) &&
    ((prio_q[4] & 16'h8f88) == 16'h0000))
    else $error("priority gap bit set");
  chk_en_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr_fire && aw_addr_q == icp_pkg::ICP_OFS_EN && w_strb_q[0]) |=>
    (en_q[icp_pkg::ICP_ERR_EN_BIT] == $past(w_data_q[icp_pkg::ICP_ERR_EN_BIT])))
    else $error("enable write lost");
  chk_write_refused: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr_fire && !wr_hit) |=> (bresp_q == icp_pkg::ICP_RESP_SLVERR))
    else $error("unmapped write not refused");
  chk_read_answer: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_rd_take |=> (rvalid_q && !arready_q))
    else $error("read answer missing");
  // a new event must land even when software clears the same bit
  chk_stat_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (|stat_set) |=> ((stat_q & $past(stat_set)) == $past(stat_set)))
    else $error("status event lost");
  chk_stat_w1c: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ((|stat_clr) && !(|stat_set)) |=> ((stat_q & $past(stat_clr)) == 17'h00000))
    else $error("status bit not cleared");
  // the interrupt trails a mask write by one cycle, so only a settled mask is held to it
  chk_irq_level: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $stable(mask_q) |-> (irq_q == (|(stat_q & mask_q))))
    else $error("interrupt level wrong");
endmodule
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  logic                     ref_clk;
  logic                     sys_rst;
  logic [7:0]               awaddr, araddr;
  logic                     awvalid, wvalid, bready, arvalid, rready;
  logic                     awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0]              wdata, rdata;
  logic [3:0]               wstrb;
  logic [1:0]               bresp, rresp;
  logic [16:0]              src_flag;
  logic [15:0]              src_en;
  logic [2:0]               serr_prio;
  icp_pkg::icp_req_t [16:0] req;
  logic [15:0]              prio_m [5];
  logic [15:0]              en_m;
  int                       n_errors = 0;
  int                       n_tests = 0;
  int                       cyc = 0;

  icp_regs DUT (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_src_flag(src_flag), .i_src_enable(src_en), .i_serial_error_priority(serr_prio),
    .o_req(req), .o_irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // a hung handshake ends the run here rather than spinning forever
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_req(input icp_pkg::icp_req_t got, input icp_pkg::icp_req_t exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t req got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] pa(input int r);
    return icp_pkg::ICP_OFS_PRIO0 + 8'(r) * icp_pkg::ICP_OFS_STEP;
  endfunction

  // the leading edge keeps a strobe from being raised in the step that dropped it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        done = 1'b1;
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
  endtask

  // expected request: flagged, enabled and nonzero level, else all zero
  task automatic chk_reqs();
    icp_pkg::icp_req_t e;
    logic [2:0]        lv;
    logic              on;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 17; i++) begin
      if (i < 16) begin
        lv = prio_m[icp_pkg::ICP_SRC_REG[i]][icp_pkg::ICP_SRC_LSB[i] +: 3];
        on = src_en[i];
      end else begin
        lv = serr_prio;
        on = en_m[1];
      end
      e.valid = src_flag[i] & on & (lv != 3'h0);
      e.level = e.valid ? lv : 3'h0;
      chk_req(req[i], e);
    end
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    src_flag = 17'h00000; src_en = 16'hffff; serr_prio = 3'h5; en_m = 16'h0000;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(icp_pkg::ICP_OFS_EN, 32'h0, icp_pkg::ICP_RESP_OKAY);
    for (int r = 0; r < 5; r++) rd(pa(r), {16'h0, 16'h4444 & icp_pkg::ICP_PRIO_MASK[r]}, 2'h0);
    rd(icp_pkg::ICP_OFS_STAT, 32'h0, icp_pkg::ICP_RESP_OKAY);
    rd(icp_pkg::ICP_OFS_MASK, 32'h0, icp_pkg::ICP_RESP_OKAY);
    wr(icp_pkg::ICP_OFS_EN, 32'hffffffff, icp_pkg::ICP_RESP_OKAY);
    en_m = 16'h0002;
    rd(icp_pkg::ICP_OFS_EN, 32'h2, icp_pkg::ICP_RESP_OKAY);
    for (int r = 0; r < 5; r++) begin
      wr(pa(r), 32'hffffffff, icp_pkg::ICP_RESP_OKAY);
      rd(pa(r), {16'h0, icp_pkg::ICP_PRIO_MASK[r]}, 2'h0);
      wr(pa(r), 32'h00006253, icp_pkg::ICP_RESP_OKAY);
      prio_m[r] = 16'h6253 & icp_pkg::ICP_PRIO_MASK[r];
    end
    src_flag <= 17'h1ffff;
    chk_reqs();
    rd(icp_pkg::ICP_OFS_FLAG, 32'h1ffff, icp_pkg::ICP_RESP_OKAY);
    wr(icp_pkg::ICP_OFS_FLAG, 32'h0, icp_pkg::ICP_RESP_OKAY);
    rd(icp_pkg::ICP_OFS_FLAG, 32'h1ffff, icp_pkg::ICP_RESP_OKAY);
    // every new request latched, but nothing unmasked yet
    rd(icp_pkg::ICP_OFS_STAT, 32'h1ffff, icp_pkg::ICP_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(icp_pkg::ICP_OFS_MASK, 32'h00010000, icp_pkg::ICP_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(icp_pkg::ICP_OFS_STAT, 32'h0000ffff, icp_pkg::ICP_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(icp_pkg::ICP_OFS_STAT, 32'h00010000, icp_pkg::ICP_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rd(icp_pkg::ICP_OFS_STAT, 32'h0, icp_pkg::ICP_RESP_OKAY);
    src_en <= 16'haaaa;
    wr(icp_pkg::ICP_OFS_EN, 32'h0, icp_pkg::ICP_RESP_OKAY);
    en_m = 16'h0000;
    chk_reqs();
    wr(icp_pkg::ICP_OFS_EN, 32'h2, icp_pkg::ICP_RESP_OKAY);
    en_m = 16'h0002;
    serr_prio <= 3'h0;
    chk_reqs();
    for (int k = 0; k < 8; k++) begin
      wr(pa(0), {16'h0, {4{1'b0, 3'(k)}}}, icp_pkg::ICP_RESP_OKAY);
      prio_m[0] = {4{1'b0, 3'(k)}};
      chk_reqs();
    end
    wr(8'h24, 32'h1, icp_pkg::ICP_RESP_SLVERR);
    rd(8'h24, 32'h0, icp_pkg::ICP_RESP_SLVERR);
    rd(icp_pkg::ICP_OFS_EN, 32'h2, icp_pkg::ICP_RESP_OKAY);
    // a second reset must undo every write made so far
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(icp_pkg::ICP_OFS_EN, 32'h0, icp_pkg::ICP_RESP_OKAY);
    rd(pa(0), 32'h4444, icp_pkg::ICP_RESP_OKAY);
    rd(pa(4), 32'h4044, icp_pkg::ICP_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
